// File: include/mjw_map.svh
`ifndef MJW_MAP_SVH
`define MJW_MAP_SVH
// register byte offsets
`define MJW_OFF_WJC 8'h00
`define MJW_OFF_NST 8'h04
`define MJW_OFF_PFC 8'h08
`define MJW_OFF_EVT 8'h0c
`define MJW_OFF_IEN 8'h10
// reset values and writable-bit masks
`define MJW_RST_WJC 32'h0000_0000
`define MJW_RST_NST 32'h0000_0000
`define MJW_RST_PFC 32'h0000_1160
`define MJW_RST_IEN 32'h0000_0000
`define MJW_NST_FIXED 32'h0008_0000
`define MJW_WM_WJC 32'h0000_0137
`define MJW_WM_NST 32'h0000_85ff
`define MJW_WM_PFC 32'hffff_7de0
`define MJW_WM_IEN 32'h0000_8209
// field positions
`define MJW_B_FJT 8
`define MJW_B_RWR 5
`define MJW_B_RWD 4
`define MJW_B_JCK 2
`define MJW_B_HUJ 1
`define MJW_B_JBD 0
`define MJW_B_ARB_NEAR_FULL_HI 15
`define MJW_B_IDLE_WIDTH_SELECT 10
`define MJW_B_EARLY_RX_BYTE_COUNT_HI 8
`define MJW_B_TM_HI 31
`define MJW_B_TM_LO 16
`define MJW_B_RESTART 14
`define MJW_B_RESTOP 13
`define MJW_B_TXEN 12
`define MJW_B_RXEN 11
`define MJW_B_RUFC 10
`define MJW_B_REJ 8
`define MJW_B_TH1 7
`define MJW_B_TH0 6
`define MJW_B_NFC 5
`define MJW_B_EVT_RXG 1
`define MJW_B_EVT_JAB 0
`define MJW_B_AIE 15
`define MJW_B_RWE 9
`define MJW_B_TJE 3
`define MJW_B_ARB_NEAR_FULL_LO 0
// timing, clock period and bit times in ns
`define MJW_CLK_NS 50
`define MJW_CYC_UP(ns) (((ns) + `MJW_CLK_NS - 1) / `MJW_CLK_NS)
`define MJW_CYC_DN(ns) ((ns) / `MJW_CLK_NS)
`define MJW_BIT_SLOW_NS 100
`define MJW_BIT_FAST_NS 10
`define MJW_JAB_SLOW_NS 26000000
`define MJW_JAB_FAST_NS 2600000
`define MJW_UNJAB_SLOW_NS 365000000
`define MJW_UNJAB_FAST_NS 36500000
`define MJW_REL_SHORT_BITS 16
`define MJW_REL_LONG_BITS 40
`define MJW_QUANTUM_BITS 512
`define MJW_IDLE_N_MIN_NS 175
`define MJW_IDLE_N_MAX_NS 225
`define MJW_IDLE_W_MIN_NS 200
`define MJW_IDLE_W_MAX_NS 250
// byte limits and fifo levels
`define MJW_CUT_BYTES 2304
`define MJW_FC_LVL_512 512
`define MJW_FC_LVL_256 256
`define MJW_FC_LVL_128 128
`define MJW_ARB_LVL_1K 1024
`endif

// File: include/mjw_pkg.sv
package mjw_pkg;
	typedef enum logic [1:0] {JB_IDLE, JB_RUN, JB_CUT} mjw_jab_st_t;
	typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_TRIP} mjw_wd_st_t;
endpackage

// File: include/mjw_cfg_if.sv
`timescale 1ns/1ps
// register words out to the core, live status back in
interface mjw_cfg_if;
	logic [31:0] wjc;
	logic [31:0] nst;
	logic [31:0] pfc;
	logic [31:0] ien;
	logic [1:0] evt;
	logic [3:0] settled;
	logic pause_ok;
	logic tx_halted;
	logic jab_trip;
	logic rxg_trip;
	modport regs (output wjc, nst, pfc, ien, evt,
		input settled, pause_ok, tx_halted, jab_trip, rxg_trip);
	modport core (input wjc, nst, pfc, ien, evt,
		output settled, pause_ok, tx_halted, jab_trip, rxg_trip);
endinterface

// File: src/mjw_regs.sv
`timescale 1ns/1ps
`include "mjw_map.svh"
module mjw_regs import mjw_pkg::*; (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata_q, // apb read data
	output logic pready_q, // apb ready
	output logic pslverr_q, // apb error on unmapped
	mjw_cfg_if.regs cfg // register words and status
);
	logic setup;
	logic wr;
	logic hit;
	logic [31:0] rd_val;
	assign setup = psel & ~penable;
	// write lands at the access edge, where pready is always high
	assign wr = psel & penable & pwrite & pready_q;

	// read mux; status bits merged live so reads never go stale
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
		`MJW_OFF_WJC: rd_val = cfg.wjc;
		`MJW_OFF_NST: rd_val = cfg.nst | `MJW_NST_FIXED |
			{cfg.pause_ok, cfg.settled, 27'h0000000};
		`MJW_OFF_PFC: rd_val = cfg.pfc | {22'h000000, cfg.tx_halted, 9'h000};
		`MJW_OFF_EVT: rd_val = {30'h00000000, cfg.evt};
		`MJW_OFF_IEN: rd_val = cfg.ien;
		default: hit = 1'b0;
		endcase
	end

	// answer is set up during the setup phase: zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit;
			if (setup && !pwrite)
				prdata_q <= rd_val;
		end
	end

	// control words, only writable bits change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg.wjc <= `MJW_RST_WJC;
			cfg.nst <= `MJW_RST_NST;
			cfg.pfc <= `MJW_RST_PFC;
			cfg.ien <= `MJW_RST_IEN;
		end else if (wr) begin
			case (paddr)
			`MJW_OFF_WJC: cfg.wjc <= pwdata & `MJW_WM_WJC;
			`MJW_OFF_NST: cfg.nst <= pwdata & `MJW_WM_NST;
			`MJW_OFF_PFC: cfg.pfc <= pwdata & `MJW_WM_PFC;
			`MJW_OFF_IEN: cfg.ien <= pwdata & `MJW_WM_IEN;
			default: cfg.ien <= cfg.ien;
			endcase
		end
	end

	// sticky timeout flags, write one to clear; a new trip beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg.evt <= 2'h0;
		else if (wr && paddr == `MJW_OFF_EVT)
			cfg.evt <= (cfg.evt & ~pwdata[1:0]) |
				{cfg.rxg_trip, cfg.jab_trip};
		else
			cfg.evt <= cfg.evt | {cfg.rxg_trip, cfg.jab_trip};
	end
endmodule

// File: src/mjw_top.sv
`timescale 1ns/1ps
`include "mjw_map.svh"
module mjw_top import mjw_pkg::*; #(
	parameter logic [23:0] JAB_SLOW_CYC = 24'(`MJW_CYC_UP(`MJW_JAB_SLOW_NS)),
	parameter logic [23:0] JAB_FAST_CYC = 24'(`MJW_CYC_UP(`MJW_JAB_FAST_NS)),
	parameter logic [23:0] UNJAB_SLOW_CYC =
		24'(`MJW_CYC_UP(`MJW_UNJAB_SLOW_NS)),
	parameter logic [23:0] UNJAB_FAST_CYC =
		24'(`MJW_CYC_UP(`MJW_UNJAB_FAST_NS))
) (
	input wire logic pclk, // core clock 20 MHz
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic speed_fast, // 1 = 100 Mb/s link
	input wire logic an_done, // auto-negotiation finished
	input wire logic an_full_duplex, // negotiated duplex
	input wire logic an_pause_ok, // partner offers pause
	input wire logic tx_active, // mac is transmitting
	input wire logic tx_byte, // one byte sent, pulse
	input wire logic rx_carrier, // receive carrier present
	input wire logic rx_byte, // one byte received, pulse
	output logic tx_cut, // jabber blocks transmit
	output logic rx_cut, // watchdog blocks receive
	input wire logic pause_rx_valid, // pause frame received, pulse
	input wire logic [15:0] pause_rx_quanta, // its pause time
	output logic pause_to_host, // pass pause frame up, pulse
	output logic tx_pause_hold, // transmit held by partner
	input wire logic [10:0] rx_fifo_level, // receive fifo bytes
	input wire logic rx_overflow, // receive fifo overflow
	input wire logic rx_desc_empty, // no receive descriptor
	output logic pause_send, // send a pause frame, pulse
	output logic [15:0] pause_send_time, // time for that frame
	output logic arb_near_full, // fifo over arbitration level
	input wire logic [8:0] rx_dma_bytes, // dma bytes of this frame
	output logic early_rx_irq, // early receive request
	input wire logic idle_pulse, // link idle pulse level
	output logic idle_pulse_ok, // valid idle pulse seen
	output logic irq // timeout interrupt
);
	mjw_cfg_if cfg ();

	mjw_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata_q(prdata),
		.pready_q(pready),
		.pslverr_q(pslverr),
		.cfg(cfg.regs)
	);

	// control fields
	logic jab_off, unjab_now, by_count, rel_long, wd_off, idle_sel;
	logic restart_m, restop_m, txfc_en, rxfc_en, rufc_en, discard, neg_acc;
	logic tx_fc_eff, rx_fc_eff;
	logic [1:0] fc_lvl, arb_sel;
	logic [8:0] early_cnt;
	logic [15:0] pause_time;
	assign jab_off = cfg.wjc[`MJW_B_JBD];
	assign unjab_now = cfg.wjc[`MJW_B_HUJ];
	assign by_count = cfg.wjc[`MJW_B_JCK];
	assign wd_off = cfg.wjc[`MJW_B_RWD];
	assign rel_long = cfg.wjc[`MJW_B_RWR];
	assign idle_sel = cfg.nst[`MJW_B_IDLE_WIDTH_SELECT];
	assign early_cnt = cfg.nst[`MJW_B_EARLY_RX_BYTE_COUNT_HI:0];
	assign arb_sel = {cfg.ien[`MJW_B_ARB_NEAR_FULL_LO], cfg.nst[`MJW_B_ARB_NEAR_FULL_HI]};
	assign pause_time = cfg.pfc[`MJW_B_TM_HI:`MJW_B_TM_LO];
	assign restart_m = cfg.pfc[`MJW_B_RESTART];
	assign restop_m = cfg.pfc[`MJW_B_RESTOP];
	assign txfc_en = cfg.pfc[`MJW_B_TXEN];
	assign rxfc_en = cfg.pfc[`MJW_B_RXEN];
	assign rufc_en = cfg.pfc[`MJW_B_RUFC];
	assign discard = cfg.pfc[`MJW_B_REJ];
	assign fc_lvl = {cfg.pfc[`MJW_B_TH1], cfg.pfc[`MJW_B_TH0]};
	assign neg_acc = cfg.pfc[`MJW_B_NFC];

	// negotiation result snapshot
	logic pause_ok_q;
	logic [3:0] settled_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_ok_q <= 1'b0;
			settled_q <= 4'h0;
		end else begin
			pause_ok_q <= an_done & an_pause_ok;
			settled_q <= an_done ? {speed_fast & an_full_duplex,
				speed_fast & ~an_full_duplex, ~speed_fast & an_full_duplex,
				~speed_fast & ~an_full_duplex} : 4'h0;
		end
	end
	assign cfg.pause_ok = pause_ok_q;
	assign cfg.settled = settled_q;
	// with negotiated accept set, a partner without pause disables both
	assign tx_fc_eff = txfc_en & (~neg_acc | pause_ok_q);
	assign rx_fc_eff = rxfc_en & (~neg_acc | pause_ok_q);

	// transmit jabber
	mjw_jab_st_t jab_st_q;
	logic [23:0] jab_cnt_q, jab_lim, unjab_lim;
	logic [11:0] jab_bytes_q;
	logic jab_hit, jab_trip_q;
	assign jab_lim = speed_fast ? JAB_FAST_CYC : JAB_SLOW_CYC;
	assign unjab_lim = speed_fast ? UNJAB_FAST_CYC : UNJAB_SLOW_CYC;
	assign jab_hit = by_count ? (jab_bytes_q >= 12'(`MJW_CUT_BYTES))
		: (jab_cnt_q >= jab_lim);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jab_st_q <= JB_IDLE;
			jab_cnt_q <= 24'h000000;
			jab_bytes_q <= 12'h000;
			tx_cut <= 1'b0;
			jab_trip_q <= 1'b0;
		end else begin
			jab_trip_q <= 1'b0;
			if (jab_off) begin
				jab_st_q <= JB_IDLE;
				tx_cut <= 1'b0;
				jab_cnt_q <= 24'h000000;
			end else begin
				case (jab_st_q)
				JB_IDLE: begin
					jab_cnt_q <= 24'h000000;
					jab_bytes_q <= 12'h000;
					if (tx_active)
						jab_st_q <= JB_RUN;
				end
				JB_RUN: begin
					if (!tx_active) begin
						jab_st_q <= JB_IDLE;
					end else if (jab_hit) begin
						jab_st_q <= JB_CUT;
						tx_cut <= 1'b1;
						jab_trip_q <= 1'b1;
						jab_cnt_q <= 24'h000000;
					end else begin
						jab_cnt_q <= jab_cnt_q + 24'h000001;
						if (tx_byte)
							jab_bytes_q <= jab_bytes_q + 12'h001;
					end
				end
				JB_CUT: begin
					// the release wait runs even if the mac keeps trying
					if (unjab_now || jab_cnt_q >= unjab_lim) begin
						jab_st_q <= JB_IDLE;
						tx_cut <= 1'b0;
					end else begin
						jab_cnt_q <= jab_cnt_q + 24'h000001;
					end
				end
				default: jab_st_q <= JB_IDLE;
				endcase
			end
		end
	end
	assign cfg.jab_trip = jab_trip_q;

	// receive watchdog
	mjw_wd_st_t wd_st_q;
	logic [11:0] wd_bytes_q;
	logic [7:0] wd_rel_q, rel_lim;
	logic rxg_trip_q;
	always_comb begin
		if (rel_long)
			rel_lim = speed_fast ?
				8'(`MJW_CYC_UP(`MJW_REL_LONG_BITS * `MJW_BIT_FAST_NS)) :
				8'(`MJW_CYC_UP(`MJW_REL_LONG_BITS * `MJW_BIT_SLOW_NS));
		else
			rel_lim = speed_fast ?
				8'(`MJW_CYC_UP(`MJW_REL_SHORT_BITS * `MJW_BIT_FAST_NS)) :
				8'(`MJW_CYC_UP(`MJW_REL_SHORT_BITS * `MJW_BIT_SLOW_NS));
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_st_q <= WD_IDLE;
			wd_bytes_q <= 12'h000;
			wd_rel_q <= 8'h00;
			rx_cut <= 1'b0;
			rxg_trip_q <= 1'b0;
		end else begin
			rxg_trip_q <= 1'b0;
			if (wd_off) begin
				wd_st_q <= WD_IDLE;
				rx_cut <= 1'b0;
			end else begin
				case (wd_st_q)
				WD_IDLE: begin
					wd_bytes_q <= 12'h000;
					if (rx_carrier)
						wd_st_q <= WD_COUNT;
				end
				WD_COUNT: begin
					if (!rx_carrier) begin
						wd_st_q <= WD_IDLE;
					end else if (wd_bytes_q >= 12'(`MJW_CUT_BYTES)) begin
						wd_st_q <= WD_TRIP;
						rx_cut <= 1'b1;
						rxg_trip_q <= 1'b1;
						wd_rel_q <= 8'h00;
					end else if (rx_byte) begin
						wd_bytes_q <= wd_bytes_q + 12'h001;
					end
				end
				WD_TRIP: begin
					// any carrier restarts the quiet interval
					if (rx_carrier) begin
						wd_rel_q <= 8'h00;
					end else if (wd_rel_q >= rel_lim) begin
						wd_st_q <= WD_IDLE;
						rx_cut <= 1'b0;
					end else begin
						wd_rel_q <= wd_rel_q + 8'h01;
					end
				end
				default: wd_st_q <= WD_IDLE;
				endcase
			end
		end
	end
	assign cfg.rxg_trip = rxg_trip_q;

	// free-running pause quantum tick, 512 bit times
	logic [10:0] qdiv_q, qlim;
	logic qtick;
	assign qlim = speed_fast ?
		11'(`MJW_CYC_UP(`MJW_QUANTUM_BITS * `MJW_BIT_FAST_NS)) :
		11'(`MJW_CYC_UP(`MJW_QUANTUM_BITS * `MJW_BIT_SLOW_NS));
	assign qtick = (qdiv_q >= qlim - 11'h001);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			qdiv_q <= 11'h000;
		else
			qdiv_q <= qtick ? 11'h000 : qdiv_q + 11'h001;
	end

	// received pause holds transmit; tick granularity is one quantum
	logic [15:0] hold_q, hold_d;
	always_comb begin
		hold_d = hold_q;
		if (!tx_fc_eff)
			hold_d = 16'h0000;
		else if (pause_rx_valid)
			hold_d = pause_rx_quanta;
		else if (qtick && hold_q != 16'h0000)
			hold_d = hold_q - 16'h0001;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 16'h0000;
			tx_pause_hold <= 1'b0;
			pause_to_host <= 1'b0;
		end else begin
			hold_q <= hold_d;
			tx_pause_hold <= (hold_d != 16'h0000);
			pause_to_host <= pause_rx_valid & ~discard;
		end
	end
	assign cfg.tx_halted = tx_pause_hold;

	// pause send threshold
	logic above, above_q, desc_q;
	logic [15:0] resend_q;
	always_comb begin
		case (fc_lvl)
		2'b11: above = rx_fifo_level >= 11'(`MJW_FC_LVL_512);
		2'b10: above = rx_fifo_level >= 11'(`MJW_FC_LVL_256);
		2'b01: above = rx_fifo_level >= 11'(`MJW_FC_LVL_128);
		default: above = rx_overflow;
		endcase
	end

	// pause frame requests; sending needs receive flow control on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			above_q <= 1'b0;
			desc_q <= 1'b0;
			resend_q <= 16'h0000;
			pause_send <= 1'b0;
			pause_send_time <= 16'h0000;
		end else begin
			above_q <= above;
			desc_q <= rx_desc_empty;
			pause_send <= 1'b0;
			if (above && qtick)
				resend_q <= resend_q + 16'h0001;
			if (!rx_fc_eff) begin
				resend_q <= 16'h0000;
			end else if (above && !above_q) begin
				pause_send <= 1'b1;
				pause_send_time <= pause_time;
				resend_q <= 16'h0000;
			end else if (!above && above_q && restart_m) begin
				pause_send <= 1'b1;
				pause_send_time <= 16'h0000;
			end else if (above && restop_m && qtick &&
				resend_q >= {1'b0, pause_time[15:1]}) begin
				// refresh before the partner's timer runs out
				pause_send <= 1'b1;
				pause_send_time <= pause_time;
				resend_q <= 16'h0000;
			end else if (rx_desc_empty && !desc_q && rufc_en) begin
				pause_send <= 1'b1;
				pause_send_time <= pause_time;
			end
		end
	end

	// arbitration level, early receive, idle pulse, interrupt
	logic [10:0] arb_lvl;
	logic [3:0] idle_w_q, idle_min, idle_max;
	logic idle_prev_q;
	always_comb begin
		case (arb_sel)
		2'b01: arb_lvl = 11'(`MJW_FC_LVL_256);
		2'b10: arb_lvl = 11'(`MJW_FC_LVL_512);
		2'b11: arb_lvl = 11'(`MJW_FC_LVL_128);
		default: arb_lvl = 11'(`MJW_ARB_LVL_1K);
		endcase
	end
	assign idle_min = idle_sel ? 4'(`MJW_CYC_UP(`MJW_IDLE_W_MIN_NS)) :
		4'(`MJW_CYC_UP(`MJW_IDLE_N_MIN_NS));
	assign idle_max = idle_sel ? 4'(`MJW_CYC_DN(`MJW_IDLE_W_MAX_NS)) :
		4'(`MJW_CYC_DN(`MJW_IDLE_N_MAX_NS));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb_near_full <= 1'b0;
			early_rx_irq <= 1'b0;
			idle_w_q <= 4'h0;
			idle_prev_q <= 1'b0;
			idle_pulse_ok <= 1'b0;
			irq <= 1'b0;
		end else begin
			arb_near_full <= rx_fifo_level >= arb_lvl;
			early_rx_irq <= (early_cnt != 9'h000) &&
				(rx_dma_bytes >= early_cnt);
			idle_prev_q <= idle_pulse;
			if (idle_pulse)
				idle_w_q <= (idle_w_q == 4'hf) ? 4'hf : idle_w_q + 4'h1;
			else
				idle_w_q <= 4'h0;
			idle_pulse_ok <= !idle_pulse && idle_prev_q &&
				idle_w_q >= idle_min && idle_w_q <= idle_max;
			irq <= cfg.ien[`MJW_B_AIE] &
				((cfg.evt[`MJW_B_EVT_RXG] & cfg.ien[`MJW_B_RWE]) |
				(cfg.evt[`MJW_B_EVT_JAB] & cfg.ien[`MJW_B_TJE]));
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_wd_off;
		wd_off |=> !rx_cut;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("watchdog cut while disabled");
	property p_jab_off;
		jab_off |=> !tx_cut && jab_st_q == JB_IDLE;
	endproperty
	a_jab_off: assert property (p_jab_off)
		else $error("jabber active while disabled");
	property p_unjab;
		jab_st_q == JB_CUT && unjab_now && !jab_off |=> !tx_cut;
	endproperty
	a_unjab: assert property (p_unjab)
		else $error("unjab did not release at once");
	property p_wd_hold;
		rx_cut && rx_carrier && !wd_off |=> rx_cut;
	endproperty
	a_wd_hold: assert property (p_wd_hold)
		else $error("receive released during carrier");
	property p_irq;
		cfg.evt[`MJW_B_EVT_JAB] && cfg.ien[`MJW_B_TJE] &&
			cfg.ien[`MJW_B_AIE] |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("jabber interrupt missing");
	property p_cut_sets_flag;
		$rose(rx_cut) |=> cfg.evt[`MJW_B_EVT_RXG];
	endproperty
	a_cut_sets_flag: assert property (p_cut_sets_flag)
		else $error("watchdog flag not set");
	property p_settled;
		an_done |=> $onehot(settled_q);
	endproperty
	a_settled: assert property (p_settled)
		else $error("settled mode not one-hot");
	property p_send_gated;
		pause_send |-> $past(rx_fc_eff);
	endproperty
	a_send_gated: assert property (p_send_gated)
		else $error("pause sent without rx flow control");
	property p_hold;
		pause_rx_valid && tx_fc_eff && pause_rx_quanta != 16'h0000
			|=> tx_pause_hold [*2];
	endproperty
	a_hold: assert property (p_hold)
		else $error("transmit not held after pause");
	property p_arb;
		arb_sel == 2'b00 && rx_fifo_level < 11'(`MJW_ARB_LVL_1K)
			|=> !arb_near_full;
	endproperty
	a_arb: assert property (p_arb)
		else $error("near full raised below 1K");

	c_jab_cut: cover property ($rose(tx_cut));
	c_wd_cut: cover property ($rose(rx_cut) ##[1:200] $fell(rx_cut));
	c_pause_send: cover property (pause_send && pause_send_time != 16'h0000);
	c_tx_hold: cover property ($rose(tx_pause_hold));
endmodule

// File: testbench/mjw_link_model.sv
`timescale 1ns/1ps
// far side of the cable: receive frames and pause frames toward the mac
module mjw_link_model (
	input wire logic pclk, // core clock
	output logic rx_carrier, // carrier on the cable
	output logic rx_byte, // one byte per cycle
	output logic pause_rx_valid, // pause frame arrived, pulse
	output logic [15:0] pause_rx_quanta // its pause time
);
	initial begin
		rx_carrier = 1'b0;
		rx_byte = 1'b0;
		pause_rx_valid = 1'b0;
		pause_rx_quanta = 16'h5a5a;
	end
	// carrier burst of n bytes, carrier and bytes drop together
	task automatic frame(input int n);
		@(posedge pclk);
		rx_carrier <= 1'b1;
		rx_byte <= 1'b1;
		repeat (n) @(posedge pclk);
		rx_carrier <= 1'b0;
		rx_byte <= 1'b0;
	endtask
	// quanta goes inverse after the pulse so a stale value cannot pass
	task automatic pause(input logic [15:0] q);
		@(posedge pclk);
		pause_rx_valid <= 1'b1;
		pause_rx_quanta <= q;
		@(posedge pclk);
		pause_rx_valid <= 1'b0;
		pause_rx_quanta <= ~q;
	endtask
endmodule

// File: testbench/mac_jabber_watchdog_flow_control_tb.sv
`timescale 1ns/1ps
`include "mjw_map.svh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
	num_errors++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
module mac_jabber_watchdog_flow_control_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic speed_fast, an_done, an_full_duplex, an_pause_ok;
	logic tx_active, tx_byte, rx_carrier, rx_byte, tx_cut, rx_cut;
	logic pause_rx_valid, pause_to_host, tx_pause_hold, pause_send;
	logic arb_near_full, early_rx_irq, idle_pulse_ok, irq;
	logic [15:0] pause_rx_quanta, pause_send_time;
	logic [10:0] rx_fifo_level;
	logic rx_overflow, rx_desc_empty, idle_pulse;
	logic [8:0] rx_dma_bytes;
	int num_errors = 0;
	int compares = 0;
	int sends = 0;
	int hosts = 0;
	int idles = 0;
	int n, lim;
	mjw_top #(.JAB_SLOW_CYC(24'd40), .JAB_FAST_CYC(24'd20),
		.UNJAB_SLOW_CYC(24'd60), .UNJAB_FAST_CYC(24'd30)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .speed_fast(speed_fast),
		.an_done(an_done), .an_full_duplex(an_full_duplex),
		.an_pause_ok(an_pause_ok), .tx_active(tx_active), .tx_byte(tx_byte),
		.rx_carrier(rx_carrier), .rx_byte(rx_byte), .tx_cut(tx_cut),
		.rx_cut(rx_cut), .pause_rx_valid(pause_rx_valid),
		.pause_rx_quanta(pause_rx_quanta), .pause_to_host(pause_to_host),
		.tx_pause_hold(tx_pause_hold), .rx_fifo_level(rx_fifo_level),
		.rx_overflow(rx_overflow), .rx_desc_empty(rx_desc_empty),
		.pause_send(pause_send),
		.pause_send_time(pause_send_time), .arb_near_full(arb_near_full),
		.rx_dma_bytes(rx_dma_bytes), .early_rx_irq(early_rx_irq),
		.idle_pulse(idle_pulse), .idle_pulse_ok(idle_pulse_ok), .irq(irq));
	mjw_link_model i_link (.pclk(pclk), .rx_carrier(rx_carrier),
		.rx_byte(rx_byte), .pause_rx_valid(pause_rx_valid),
		.pause_rx_quanta(pause_rx_quanta));
	// 20 MHz core clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// count requested pause frames; a pulse lasts one cycle only
	always @(posedge pclk) begin
		if (pause_send === 1'b1)
			sends <= sends + 1;
		if (pause_to_host === 1'b1)
			hosts <= hosts + 1;
		if (idle_pulse_ok === 1'b1)
			idles <= idles + 1;
	end
	// idle pulse of w cycles, then quiet long enough to be judged
	task automatic ipulse(input int w);
		@(posedge pclk);
		idle_pulse <= 1'b1;
		repeat (w) @(posedge pclk);
		idle_pulse <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	// apb master: request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rd)
	endtask
	task automatic tend(input string s);
		$display("test %s over, errors %0d", s, num_errors);
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, well above the expected 12k cycles
	initial begin
		repeat (40000) @(posedge pclk);
		num_errors++;
		test_done;
	end
	initial begin
		{presetn, psel, penable, pwrite, tx_active, tx_byte} = 6'h00;
		{speed_fast, an_done, an_full_duplex, an_pause_ok} = 4'hf;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rx_fifo_level = 11'h000;
		{rx_overflow, rx_desc_empty, idle_pulse} = 3'h0;
		rx_dma_bytes = 9'h000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`MJW_OFF_PFC, 32'h0000_1160, "pfc");
		rdc(`MJW_OFF_WJC, 32'h0000_0000, "wjc");
		rdc(`MJW_OFF_NST, 32'hc008_0000, "nst");
		apb(1'b0, 8'h14, 32'h0000_0000);
		`CHK("unmapped", 1'b1, err)
		tend("reset");
		// time cut, byte-count cut, then time cut with immediate unjab
		apb(1'b1, `MJW_OFF_IEN, 32'h0000_8008);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, `MJW_OFF_WJC, m == 1 ? 32'h4 : (m == 2 ? 32'h2 : 32'h0));
			lim = m == 1 ? 2304 : 20;
			tx_active <= 1'b1;
			tx_byte <= 1'b1;
			n = 0;
			while (tx_cut !== 1'b1 && n < 3000) begin
				@(posedge pclk);
				n++;
			end
			tx_active <= 1'b0;
			tx_byte <= 1'b0;
			`CHK("cut_len", 1'b1, n >= lim && n <= lim + 5)
			repeat (m == 2 ? 3 : 25) @(posedge pclk);
			`CHK("cut_hold", m != 2, tx_cut)
			`CHK("jab_irq", 1'b1, irq)
			repeat (10) @(posedge pclk);
			`CHK("cut_free", 1'b0, tx_cut)
			rdc(`MJW_OFF_EVT, 32'h0000_0001, "evt_jab");
			apb(1'b1, `MJW_OFF_EVT, 32'h0000_0001);
		end
		apb(1'b1, `MJW_OFF_WJC, 32'h0000_0001);
		tx_active <= 1'b1;
		repeat (60) @(posedge pclk);
		`CHK("jab_off", 1'b0, tx_cut)
		tx_active <= 1'b0;
		tend("jabber");
		// watchdog trip and release, short then long interval
		apb(1'b1, `MJW_OFF_IEN, 32'h0000_8200);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, `MJW_OFF_WJC, s ? 32'h20 : 32'h0);
			i_link.frame(2400);
			`CHK("rx_trip", 1'b1, rx_cut)
			repeat (s ? 6 : 2) @(posedge pclk);
			`CHK("rx_hold", 1'b1, rx_cut)
			repeat (10) @(posedge pclk);
			`CHK("rx_free", 1'b0, rx_cut)
			`CHK("rx_irq", 1'b1, irq)
			apb(1'b1, `MJW_OFF_EVT, 32'h0000_0002);
		end
		apb(1'b1, `MJW_OFF_WJC, 32'h0000_0010);
		i_link.frame(2400);
		`CHK("rx_off", 1'b0, rx_cut)
		apb(1'b1, `MJW_OFF_WJC, 32'h0000_0000);
		i_link.frame(2000);
		`CHK("rx_short", 1'b0, rx_cut)
		tend("watchdog");
		// received pause holds transmit for two quanta
		i_link.pause(16'h0002);
		@(posedge pclk);
		`CHK("tx_hold", 1'b1, tx_pause_hold)
		rdc(`MJW_OFF_PFC, 32'h0000_1360, "pfc_halt");
		repeat (300) @(posedge pclk);
		`CHK("tx_resume", 1'b0, tx_pause_hold)
		// fifo level codes 1 to 3: below stays quiet, above sends once
		for (int c = 1; c < 4; c++) begin
			lim = c == 3 ? 512 : (c == 2 ? 256 : 128);
			apb(1'b1, `MJW_OFF_PFC, 32'h1234_1920 | (c << 6));
			rx_fifo_level <= 11'(lim - 8);
			n = sends;
			repeat (4) @(posedge pclk);
			`CHK("below", 1'b1, sends == n)
			rx_fifo_level <= 11'(lim + 8);
			repeat (4) @(posedge pclk);
			`CHK("above", 1'b1, sends == n + 1)
			`CHK("ptime", 16'h1234, pause_send_time)
			rx_fifo_level <= 11'h000;
			repeat (4) @(posedge pclk);
		end
		tend("pause");
		// no-descriptor and overflow requests, then discard of pause frames
		apb(1'b1, `MJW_OFF_PFC, 32'h00ab_1d20);
		n = sends;
		rx_desc_empty <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("desc_send", 1'b1, sends == n + 1)
		`CHK("desc_time", 16'h00ab, pause_send_time)
		rx_overflow <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("ovf_send", 1'b1, sends == n + 2)
		{rx_overflow, rx_desc_empty} <= 2'b00;
		n = hosts;
		i_link.pause(16'h0000);
		apb(1'b1, `MJW_OFF_PFC, 32'h00ab_1c20);
		i_link.pause(16'h0000);
		repeat (2) @(posedge pclk);
		`CHK("to_host", 1'b1, hosts == n + 1)
		// arbitration level, early receive count, idle pulse widths
		rx_fifo_level <= 11'd300;
		rx_dma_bytes <= 9'd15;
		repeat (3) @(posedge pclk);
		`CHK("arb_1k", 1'b0, arb_near_full)
		`CHK("early_off", 1'b0, early_rx_irq)
		apb(1'b1, `MJW_OFF_NST, 32'h0000_8010);
		repeat (2) @(posedge pclk);
		`CHK("arb_256", 1'b1, arb_near_full)
		`CHK("early_lo", 1'b0, early_rx_irq)
		rx_dma_bytes <= 9'd16;
		repeat (3) @(posedge pclk);
		`CHK("early_hi", 1'b1, early_rx_irq)
		n = idles;
		ipulse(4);
		ipulse(6);
		`CHK("idle_norm", 1'b1, idles == n + 1)
		apb(1'b1, `MJW_OFF_NST, 32'h0000_8410);
		ipulse(5);
		ipulse(3);
		`CHK("idle_wide", 1'b1, idles == n + 2)
		// slow half duplex without pause, then negotiation gone
		{speed_fast, an_full_duplex, an_pause_ok} <= 3'h0;
		repeat (2) @(posedge pclk);
		rdc(`MJW_OFF_NST, 32'h0808_8410, "nst_slow");
		an_done <= 1'b0;
		repeat (2) @(posedge pclk);
		rdc(`MJW_OFF_NST, 32'h0008_8410, "nst_none");
		tend("misc");
		test_done;
	end
endmodule
